/* File: hdl/udc_counter.sv */
module udc_counter
  import udc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // event pins: per channel A, B, index
  input wire logic [5:0] evtPin,
  // interrupt
  output logic irq
);
  // pin synchronisers and filter
  logic [5:0] syncA, syncB, syncC, filt, filtPrev;
  logic [5:0] next_filt;
  logic [PRE_W-1:0] pre, next_pre;
  logic [7:0] cnt [2];
  logic [7:0] rc [2];
  logic [7:0] stat [2];
  logic [7:0] ctlLo [2];
  logic [7:0] ctlHi [2];
  logic [1:0] dirFlag [2];
  logic [7:0] next_cnt [2];
  logic [7:0] next_rc [2];
  logic [7:0] next_stat [2];
  logic [7:0] next_ctlLo [2];
  logic [7:0] next_ctlHi [2];
  logic [1:0] next_dirFlag [2];
  logic [7:0] next_rdata;
  logic [1:0] upReq, dnReq, zClr;
  udc_step_t stepRes [2];
  logic fastTick, slowTick, m16;

  function automatic logic edgeHit(input logic [1:0] sel,
                                   input logic rise, input logic fall);
    edgeHit = (sel[0] & rise) | (sel[1] & fall);
  endfunction : edgeHit

  function automatic udc_step_t stepCount(input logic [15:0] v,
      input logic [15:0] rcv, input logic [15:0] maxv, input logic up,
      input logic dn, input logic reload_function_enable, input logic compare_clear_enable);
    udc_step_t r;
    r = '{val: v, ovf: 1'b0, udf: 1'b0, cmp: 1'b0};
    if (up) begin
      if (v == maxv) begin
        r.val = 16'h0000;
        r.ovf = 1'b1;
      end else begin
        r.val = v + 16'h0001;
      end
    end else if (dn) begin
      if (v == 16'h0000) begin
        r.udf = 1'b1;
        r.val = reload_function_enable ? rcv : maxv;
      end else begin
        r.val = v - 16'h0001;
      end
    end
    if ((up | dn) && r.val == rcv) begin
      r.cmp = 1'b1;
      if (compare_clear_enable && up) begin
        r.val = 16'h0000;
      end
    end
    stepCount = r;
  endfunction : stepCount

  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : g_sync
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          syncA[g] <= 1'b0;
          syncB[g] <= 1'b0;
          syncC[g] <= 1'b0;
        end else if (ce) begin
          syncA[g] <= evtPin[g];
          syncB[g] <= syncA[g];
          syncC[g] <= syncB[g];
        end
      end
      assign next_filt[g] = (syncB[g] == syncC[g]) ? syncC[g] : filt[g];
    end
  endgenerate

  assign m16 = ctlHi[0][B_CASCADE_16BIT_ENABLE];
  assign next_pre = pre + {{(PRE_W-1){1'b0}}, 1'b1};
  assign fastTick = &pre[FAST_W-1:0];
  assign slowTick = &pre;

  // count request decode per channel
  always_comb begin
    logic a, b, z, aR, aF, bR, bF, zR, zF, gateOpen;
    udc_mode_t mode;
    a = 1'b0;
    b = 1'b0;
    z = 1'b0;
    aR = 1'b0;
    aF = 1'b0;
    bR = 1'b0;
    bF = 1'b0;
    zR = 1'b0;
    zF = 1'b0;
    gateOpen = 1'b0;
    mode = MODE_TIMER;
    for (int i = 0; i < 2; i++) begin
      a = filt[3*i];
      b = filt[3*i+1];
      z = filt[3*i+2];
      aR = a & ~filtPrev[3*i];
      aF = ~a & filtPrev[3*i];
      bR = b & ~filtPrev[3*i+1];
      bF = ~b & filtPrev[3*i+1];
      zR = z & ~filtPrev[3*i+2];
      zF = ~z & filtPrev[3*i+2];
      upReq[i] = 1'b0;
      dnReq[i] = 1'b0;
      mode = udc_mode_t'(ctlHi[i][3:2]);
      case (mode)
        MODE_TIMER: begin
          dnReq[i] = ctlHi[i][B_TIMER_CLOCK_SEL] ? slowTick : fastTick;
        end
        MODE_UPDOWN: begin
          upReq[i] = edgeHit(ctlHi[i][1:0], aR, aF);
          dnReq[i] = edgeHit(ctlHi[i][1:0], bR, bF);
        end
        MODE_PHASE2: begin
          upReq[i] = (aR & ~b) | (aF & b);
          dnReq[i] = (aR & b) | (aF & ~b);
        end
        MODE_PHASE4: begin
          upReq[i] = (aR & ~b) | (aF & b) | (bR & a) | (bF & ~a);
          dnReq[i] = (aR & b) | (aF & ~b) | (bR & ~a) | (bF & a);
        end
        default: begin
          upReq[i] = 1'b0;
          dnReq[i] = 1'b0;
        end
      endcase
      // index pin: clear on edge, or gate by level
      zClr[i] = ~ctlLo[i][B_INDEX_FUNCTION_SEL] & edgeHit(ctlLo[i][1:0], zR, zF);
      gateOpen = ~ctlLo[i][B_INDEX_FUNCTION_SEL] || ctlLo[i][1:0] == 2'b00 ||
        ctlLo[i][1:0] == 2'b11 || (ctlLo[i][0] ? z : ~z);
      if (!stat[i][B_RUN] || !gateOpen || (upReq[i] & dnReq[i]) ||
          (i == 1 && m16)) begin
        upReq[i] = 1'b0;
        dnReq[i] = 1'b0;
      end
    end
  end

  // next state of the register file and counters
  always_comb begin
    logic wrHit;
    logic [7:0] clr;
    logic [7:0] sBase, sAddr, lAddr, hAddr;
    wrHit = 1'b0;
    clr = 8'h00;
    sBase = 8'h00;
    sAddr = 8'h00;
    lAddr = 8'h00;
    hAddr = 8'h00;
    for (int i = 0; i < 2; i++) begin
      next_cnt[i] = cnt[i];
      next_rc[i] = rc[i];
      next_stat[i] = stat[i];
      next_ctlLo[i] = ctlLo[i];
      next_ctlHi[i] = ctlHi[i];
      next_dirFlag[i] = dirFlag[i];
      stepRes[i] = '{val: 16'h0000, ovf: 1'b0, udf: 1'b0, cmp: 1'b0};
    end
    // joined mode works on the 16-bit pair, flags kept on channel 0
    if (m16) begin
      stepRes[0] = stepCount({cnt[1], cnt[0]}, {rc[1], rc[0]}, MAX16,
        upReq[0], dnReq[0], ctlLo[0][B_RELOAD_FUNCTION_ENABLE], ctlLo[0][B_COMPARE_CLEAR_ENABLE]);
      next_cnt[0] = stepRes[0].val[7:0];
      next_cnt[1] = stepRes[0].val[15:8];
    end else begin
      for (int i = 0; i < 2; i++) begin
        stepRes[i] = stepCount({8'h00, cnt[i]}, {8'h00, rc[i]}, MAX8,
          upReq[i], dnReq[i], ctlLo[i][B_RELOAD_FUNCTION_ENABLE], ctlLo[i][B_COMPARE_CLEAR_ENABLE]);
        next_cnt[i] = stepRes[i].val[7:0];
      end
    end
    for (int i = 0; i < 2; i++) begin
      if (zClr[i]) begin
        next_cnt[i] = RST_COUNT;
        if (i == 0 && m16) begin
          next_cnt[1] = RST_COUNT;
        end
      end
      if (upReq[i] | dnReq[i]) begin
        next_dirFlag[i] = upReq[i] ? DIR_UP : DIR_DOWN;
      end
    end
    // software side: write-one-to-clear flags, hardware set wins
    for (int i = 0; i < 2; i++) begin
      sAddr = i[0] ? ADDR_STATUS1 : ADDR_STATUS0;
      lAddr = i[0] ? ADDR_CTRLLO1 : ADDR_CTRLLO0;
      hAddr = i[0] ? ADDR_CTRLHI1 : ADDR_CTRLHI0;
      sBase = i[0] ? ADDR_RELOAD1 : ADDR_RELOAD0;
      clr = 8'h00;
      if (wr && addr == sBase) begin
        next_rc[i] = wdata;
      end
      if (wr && addr == sAddr) begin
        next_stat[i][7:5] = wdata[7:5];
        clr = wdata;
      end
      if (wr && addr == lAddr) begin
        next_ctlLo[i] = {2'b00, wdata[B_COMPARE_CLEAR_ENABLE:B_RELOAD_FUNCTION_ENABLE], 1'b0, wdata[2:0]};
        if (wdata[B_CLEAR]) begin
          next_cnt[i] = RST_COUNT;
        end
        if (wdata[B_LOAD]) begin
          next_cnt[i] = rc[i];
        end
      end
      wrHit = wr && addr == hAddr;
      if (wrHit) begin
        next_ctlHi[i] = {i[0] ? 1'b0 : wdata[B_CASCADE_16BIT_ENABLE], next_ctlHi[i][B_DIRECTION_CHANGE_FLAG],
          wdata[5:0]};
      end
      next_stat[i][B_COMPARE_MATCH_FLAG] = (stat[i][B_COMPARE_MATCH_FLAG] & ~clr[B_COMPARE_MATCH_FLAG]) |
        stepRes[i].cmp;
      next_stat[i][B_OVERFLOW_FLAG] = (stat[i][B_OVERFLOW_FLAG] & ~clr[B_OVERFLOW_FLAG]) |
        stepRes[i].ovf;
      next_stat[i][B_UNDERFLOW_FLAG] = (stat[i][B_UNDERFLOW_FLAG] & ~clr[B_UNDERFLOW_FLAG]) |
        stepRes[i].udf;
      next_ctlHi[i][B_DIRECTION_CHANGE_FLAG] = (ctlHi[i][B_DIRECTION_CHANGE_FLAG] &
        ~(wrHit & wdata[B_DIRECTION_CHANGE_FLAG])) | (dirFlag[i] != DIR_NONE &&
        next_dirFlag[i] != dirFlag[i]);
      next_stat[i][1:0] = next_dirFlag[i];
    end
    // read mux, data valid only in the cycle after the strobe
    next_rdata = 8'h00;
    if (rd) begin
      case (addr)
        ADDR_COUNT0: next_rdata = cnt[0];
        ADDR_COUNT1: next_rdata = cnt[1];
        ADDR_STATUS0: next_rdata = stat[0];
        ADDR_STATUS1: next_rdata = stat[1];
        ADDR_CTRLLO0: next_rdata = ctlLo[0];
        ADDR_CTRLLO1: next_rdata = ctlLo[1];
        ADDR_CTRLHI0: next_rdata = ctlHi[0];
        ADDR_CTRLHI1: next_rdata = ctlHi[1];
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      filt <= 6'h00;
      filtPrev <= 6'h00;
      pre <= '0;
      rdata <= 8'h00;
      for (int i = 0; i < 2; i++) begin
        cnt[i] <= RST_COUNT;
        rc[i] <= RST_RELOAD;
        stat[i] <= RST_STATUS;
        dirFlag[i] <= DIR_NONE;
      end
      ctlLo[0] <= RST_CTRLLO0;
      ctlLo[1] <= RST_CTRLLO1;
      ctlHi[0] <= RST_CTRLHI0;
      ctlHi[1] <= RST_CTRLHI1;
    end else if (ce) begin
      filt <= next_filt;
      filtPrev <= filt;
      pre <= next_pre;
      rdata <= next_rdata;
      for (int i = 0; i < 2; i++) begin
        cnt[i] <= next_cnt[i];
        rc[i] <= next_rc[i];
        stat[i] <= next_stat[i];
        ctlLo[i] <= next_ctlLo[i];
        ctlHi[i] <= next_ctlHi[i];
        dirFlag[i] <= next_dirFlag[i];
      end
    end
  end

  always_comb begin
    irq = 1'b0;
    for (int i = 0; i < 2; i++) begin
      irq = irq | (stat[i][B_COMPARE_MATCH_FLAG] & stat[i][B_COMPARE_IRQ_ENABLE]) |
        ((stat[i][B_OVERFLOW_FLAG] | stat[i][B_UNDERFLOW_FLAG]) & stat[i][B_WRAP_IRQ_ENABLE]) |
        (ctlHi[i][B_DIRECTION_CHANGE_FLAG] & ctlHi[i][B_DIRECTION_CHANGE_IRQ_ENABLE]);
    end
  end

  a_timer_down: assert property (@(posedge clk) disable iff (rst)
    ce && stat[0][B_RUN] && ctlHi[0][3:2] == 2'b00 && dnReq[0]
    |=> dirFlag[0] == DIR_DOWN)
    else $error("timer mode did not count down");

  a_edge_none: assert property (@(posedge clk) disable iff (rst)
    ctlHi[0][3:2] == 2'b01 && ctlHi[0][1:0] == 2'b00
    |-> !upReq[0] && !dnReq[0])
    else $error("edges counted with no edge selected");

  a_phase_up: assert property (@(posedge clk) disable iff (rst)
    stat[0][B_RUN] && ctlHi[0][3:2] == 2'b10 && !ctlLo[0][B_INDEX_FUNCTION_SEL] &&
    filt[0] && !filtPrev[0] && !filt[1] && !m16 |-> upReq[0])
    else $error("phase lead did not count up");

  a_index_clear: assert property (@(posedge clk) disable iff (rst)
    ce && zClr[0] && !wr |=> cnt[0] == 8'h00)
    else $error("index edge did not clear count");

  a_reload_udf: assert property (@(posedge clk) disable iff (rst)
    ce && !m16 && dnReq[0] && cnt[0] == 8'h00 && ctlLo[0][B_RELOAD_FUNCTION_ENABLE] &&
    !zClr[0] && !wr && rc[0] != 8'h00
    |=> cnt[0] == $past(rc[0]) && stat[0][B_UNDERFLOW_FLAG])
    else $error("underflow did not reload");

  a_irq_cmp: assert property (@(posedge clk) disable iff (rst)
    ce && stepRes[0].cmp && stat[0][B_COMPARE_IRQ_ENABLE] && !wr |=> irq)
    else $error("compare match raised no interrupt");

  a_dir_flip: assert property (@(posedge clk) disable iff (rst)
    $past(dirFlag[0]) == DIR_UP && dirFlag[0] == DIR_DOWN
    |-> ctlHi[0][B_DIRECTION_CHANGE_FLAG])
    else $error("reversal did not set flag");

  a_dir_ro: assert property (@(posedge clk) disable iff (rst)
    ce && wr && addr == ADDR_STATUS0 && !upReq[0] && !dnReq[0]
    |=> $stable(dirFlag[0]))
    else $error("direction flags written by software");

  a_carry_hi: assert property (@(posedge clk) disable iff (rst)
    ce && m16 && upReq[0] && cnt[0] == 8'hff && cnt[1] != 8'hff &&
    !zClr[0] && !wr && !ctlLo[0][B_COMPARE_CLEAR_ENABLE] && {rc[1], rc[0]} != 16'h0000
    |=> cnt[1] == 8'($past(cnt[1]) + 8'h01))
    else $error("carry did not reach high byte");

  a_reload_wo: assert property (@(posedge clk) disable iff (rst)
    ce && rd && (addr == ADDR_RELOAD0 || addr == ADDR_RELOAD1)
    |=> rdata == 8'h00)
    else $error("reload register was readable");

  a_cmp_clear: assert property (@(posedge clk) disable iff (rst)
    ce && upReq[1] && ctlLo[1][B_COMPARE_CLEAR_ENABLE] && cnt[1] != 8'hff &&
    8'(cnt[1] + 8'h01) == rc[1] && !zClr[1] && !wr
    |=> cnt[1] == 8'h00 && stat[1][B_COMPARE_MATCH_FLAG])
    else $error("compare match did not clear count");

  a_ovf_wrap: assert property (@(posedge clk) disable iff (rst)
    ce && upReq[1] && cnt[1] == 8'hff && !zClr[1] && !wr
    |=> cnt[1] == 8'h00 && stat[1][B_OVERFLOW_FLAG])
    else $error("overflow did not wrap to zero");
endmodule : udc_counter

/* File: inc/udc_pkg.sv */
package udc_pkg;
  // register offsets
  localparam logic [7:0] ADDR_COUNT0 = 8'h70;
  localparam logic [7:0] ADDR_COUNT1 = 8'h71;
  localparam logic [7:0] ADDR_RELOAD0 = 8'h72;
  localparam logic [7:0] ADDR_RELOAD1 = 8'h73;
  localparam logic [7:0] ADDR_STATUS0 = 8'h74;
  localparam logic [7:0] ADDR_CTRLLO0 = 8'h76;
  localparam logic [7:0] ADDR_CTRLHI0 = 8'h77;
  localparam logic [7:0] ADDR_STATUS1 = 8'h78;
  localparam logic [7:0] ADDR_CTRLLO1 = 8'h7a;
  localparam logic [7:0] ADDR_CTRLHI1 = 8'h7b;
  // reset values
  localparam logic [7:0] RST_COUNT = 8'h00;
  localparam logic [7:0] RST_RELOAD = 8'h00;
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [7:0] RST_CTRLLO0 = 8'h10;
  localparam logic [7:0] RST_CTRLLO1 = 8'h00;
  localparam logic [7:0] RST_CTRLHI0 = 8'h00;
  localparam logic [7:0] RST_CTRLHI1 = 8'h08;
  // status fields
  localparam int B_RUN = 7;
  localparam int B_COMPARE_IRQ_ENABLE = 6;
  localparam int B_WRAP_IRQ_ENABLE = 5;
  localparam int B_COMPARE_MATCH_FLAG = 4;
  localparam int B_OVERFLOW_FLAG = 3;
  localparam int B_UNDERFLOW_FLAG = 2;
  // control low fields
  localparam int B_LOAD = 6;
  localparam int B_COMPARE_CLEAR_ENABLE = 5;
  localparam int B_RELOAD_FUNCTION_ENABLE = 4;
  localparam int B_CLEAR = 3;
  localparam int B_INDEX_FUNCTION_SEL = 2;
  // control high fields
  localparam int B_CASCADE_16BIT_ENABLE = 7;
  localparam int B_DIRECTION_CHANGE_FLAG = 6;
  localparam int B_DIRECTION_CHANGE_IRQ_ENABLE = 5;
  localparam int B_TIMER_CLOCK_SEL = 4;
  // count limits
  localparam logic [15:0] MAX8 = 16'h00ff;
  localparam logic [15:0] MAX16 = 16'hffff;
  // timer prescaler: fast tick every 2, slow every 8 cycles
  localparam int PRE_W = 3;
  localparam int FAST_W = 1;
  // direction flag codes
  localparam logic [1:0] DIR_NONE = 2'b00;
  localparam logic [1:0] DIR_UP = 2'b01;
  localparam logic [1:0] DIR_DOWN = 2'b10;
  typedef enum logic [1:0] {
    MODE_TIMER = 2'b00,
    MODE_UPDOWN = 2'b01,
    MODE_PHASE2 = 2'b10,
    MODE_PHASE4 = 2'b11
  } udc_mode_t;
  typedef struct packed {
    logic [15:0] val;
    logic ovf;
    logic udf;
    logic cmp;
  } udc_step_t;
endpackage : udc_pkg

/* File: tb/udc_event_model.sv */
module udc_event_model (
  // clock
  input wire logic clk,
  // event pins: A, B, index per channel
  output logic [5:0] evtPin
);
  timeunit 1ns;
  timeprecision 1ns;

  initial evtPin = 6'h00;

  // each level stands seven cycles, beyond the input filter
  task automatic hold(input int pin, input logic val);
    @(posedge clk);
    evtPin[pin] <= val;
    repeat (6) @(posedge clk);
  endtask : hold

  task automatic pulse(input int pin);
    hold(pin, 1'b1);
    hold(pin, 1'b0);
  endtask : pulse

  // forward: A leads B; reverse: B leads A
  task automatic quad(input int base, input bit fwd, input int n);
    for (int i = 0; i < n; i++) begin
      hold(fwd ? base : base + 1, 1'b1);
      hold(fwd ? base + 1 : base, 1'b1);
      hold(fwd ? base : base + 1, 1'b0);
      hold(fwd ? base + 1 : base, 1'b0);
    end
  endtask : quad
endmodule : udc_event_model

/* File: tb/tb.sv */
module tb
  import udc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst;
  logic ce;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic [5:0] evtPin;
  logic irq;
  int n_mismatch = 0;
  int comparisons = 0;
  logic [7:0] v;

  udc_counter dut (.clk(clk), .rst(rst), .ce(ce), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .evtPin(evtPin),
    .irq(irq));
  udc_event_model enc (.clk(clk), .evtPin(evtPin));

  initial begin
    forever #50 clk = ~clk;
  end

  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    @(negedge clk);
  endtask : wreg

  task automatic rreg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask : rreg

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic rchk(input logic [7:0] a, input logic [7:0] m,
                      input logic [7:0] exp);
    logic [7:0] d;
    rreg(a, d);
    chk(d & m, exp);
  endtask : rchk

  task automatic conclude();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : conclude

  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    conclude();
  end

  initial begin
    logic [7:0] ra[11] = '{8'h70, 8'h71, 8'h72, 8'h73, 8'h74, 8'h76,
                           8'h77, 8'h78, 8'h7a, 8'h7b, 8'h75};
    logic [7:0] rv[11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h10,
                           8'h00, 8'h00, 8'h00, 8'h08, 8'h00};
    rst <= 1'b1;
    ce <= 1'b1;
    addr <= 8'h00;
    wdata <= 8'h00;
    wr <= 1'b0;
    rd <= 1'b0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 11; i++) rchk(ra[i], 8'hff, rv[i]);
    wreg(ADDR_COUNT0, 8'h5a);
    rchk(ADDR_COUNT0, 8'hff, 8'h00);
    $display("reset values done");
    // up/down mode, rising edges, ch0
    wreg(ADDR_CTRLHI0, 8'h05);
    wreg(ADDR_STATUS0, 8'h80);
    repeat (3) enc.pulse(0);
    rchk(ADDR_COUNT0, 8'hff, 8'h03);
    rchk(ADDR_STATUS0, 8'h03, 8'h01);
    rchk(ADDR_CTRLHI0, 8'h40, 8'h00);
    enc.pulse(1);
    rchk(ADDR_COUNT0, 8'hff, 8'h02);
    rchk(ADDR_STATUS0, 8'h03, 8'h02);
    rchk(ADDR_CTRLHI0, 8'h40, 8'h40);
    wreg(ADDR_CTRLHI0, 8'h25);
    chk({7'h00, irq}, 8'h01);
    wreg(ADDR_CTRLHI0, 8'h65);
    chk({7'h00, irq}, 8'h00);
    $display("edge count done");
    // underflow reloads the stored value
    wreg(ADDR_RELOAD0, 8'h05);
    wreg(ADDR_STATUS0, 8'hc0);
    repeat (3) enc.pulse(1);
    rchk(ADDR_COUNT0, 8'hff, 8'h05);
    rchk(ADDR_STATUS0, 8'h04, 8'h04);
    chk({7'h00, irq}, 8'h01);
    wreg(ADDR_STATUS0, 8'ha0);
    chk({7'h00, irq}, 8'h01);
    wreg(ADDR_STATUS0, 8'h9f);
    chk({7'h00, irq}, 8'h00);
    rchk(ADDR_STATUS0, 8'h1f, 8'h02);
    $display("reload done");
    // ch1 compare match, then overflow
    wreg(ADDR_RELOAD1, 8'h10);
    wreg(ADDR_CTRLHI1, 8'h05);
    wreg(ADDR_STATUS1, 8'h80);
    repeat (16) enc.pulse(3);
    rchk(ADDR_COUNT1, 8'hff, 8'h10);
    rchk(ADDR_STATUS1, 8'h10, 8'h10);
    wreg(ADDR_STATUS1, 8'hc0);
    chk({7'h00, irq}, 8'h01);
    wreg(ADDR_STATUS1, 8'h9c);
    chk({7'h00, irq}, 8'h00);
    repeat (240) enc.pulse(3);
    rchk(ADDR_COUNT1, 8'hff, 8'h00);
    rchk(ADDR_STATUS1, 8'h0b, 8'h09);
    $display("compare and overflow done");
    // phase x4 with compare-clear and reload on ch1
    wreg(ADDR_RELOAD1, 8'h03);
    wreg(ADDR_CTRLLO1, 8'h30);
    wreg(ADDR_CTRLHI1, 8'h0c);
    enc.quad(3, 1'b1, 1);
    rchk(ADDR_COUNT1, 8'hff, 8'h01);
    rchk(ADDR_STATUS1, 8'h10, 8'h10);
    enc.quad(3, 1'b0, 1);
    rchk(ADDR_COUNT1, 8'hff, 8'h01);
    rchk(ADDR_STATUS1, 8'h04, 8'h04);
    wreg(ADDR_CTRLLO1, 8'h08);
    $display("phase x4 done");
    // timer mode, fast then slow tick
    wreg(ADDR_STATUS0, 8'h1c);
    wreg(ADDR_CTRLHI0, 8'h00);
    wreg(ADDR_RELOAD0, 8'h20);
    wreg(ADDR_CTRLLO0, 8'h50);
    wreg(ADDR_STATUS0, 8'h80);
    repeat (20) @(posedge clk);
    wreg(ADDR_STATUS0, 8'h00);
    rreg(ADDR_COUNT0, v);
    chk({7'h00, v inside {[8'h14 : 8'h18]}}, 8'h01);
    wreg(ADDR_CTRLHI0, 8'h10);
    wreg(ADDR_CTRLLO0, 8'h50);
    wreg(ADDR_STATUS0, 8'h80);
    repeat (20) @(posedge clk);
    wreg(ADDR_STATUS0, 8'h00);
    rreg(ADDR_COUNT0, v);
    chk({7'h00, v inside {[8'h1c : 8'h1e]}}, 8'h01);
    $display("timer done");
    // phase difference x2
    wreg(ADDR_CTRLHI0, 8'h08);
    wreg(ADDR_CTRLLO0, 8'h18);
    wreg(ADDR_STATUS0, 8'h80);
    enc.quad(0, 1'b1, 2);
    rchk(ADDR_COUNT0, 8'hff, 8'h04);
    enc.quad(0, 1'b0, 1);
    rchk(ADDR_COUNT0, 8'hff, 8'h02);
    rchk(ADDR_STATUS0, 8'h03, 8'h02);
    // index pin: clear, then gate
    wreg(ADDR_CTRLLO0, 8'h11);
    enc.pulse(2);
    rchk(ADDR_COUNT0, 8'hff, 8'h00);
    wreg(ADDR_CTRLHI0, 8'h05);
    wreg(ADDR_CTRLLO0, 8'h15);
    enc.pulse(0);
    rchk(ADDR_COUNT0, 8'hff, 8'h00);
    enc.hold(2, 1'b1);
    enc.pulse(0);
    enc.hold(2, 1'b0);
    rchk(ADDR_COUNT0, 8'hff, 8'h01);
    $display("phase and index done");
    // 16-bit cascade borrow and carry
    wreg(ADDR_CTRLLO0, 8'h08);
    wreg(ADDR_CTRLHI0, 8'h85);
    wreg(ADDR_STATUS0, 8'h9c);
    enc.pulse(1);
    rchk(ADDR_COUNT0, 8'hff, 8'hff);
    rchk(ADDR_COUNT1, 8'hff, 8'hff);
    rchk(ADDR_STATUS0, 8'h04, 8'h04);
    enc.pulse(0);
    rchk(ADDR_COUNT0, 8'hff, 8'h00);
    rchk(ADDR_COUNT1, 8'hff, 8'h00);
    rchk(ADDR_STATUS0, 8'h08, 8'h08);
    wreg(ADDR_RELOAD0, 8'hff);
    wreg(ADDR_CTRLLO0, 8'h40);
    enc.pulse(0);
    rchk(ADDR_COUNT0, 8'hff, 8'h00);
    rchk(ADDR_COUNT1, 8'hff, 8'h01);
    $display("cascade done");
    // frozen clock enable, then no edge selected
    @(posedge clk);
    ce <= 1'b0;
    enc.pulse(0);
    @(posedge clk);
    ce <= 1'b1;
    rchk(ADDR_COUNT0, 8'hff, 8'h00);
    wreg(ADDR_CTRLHI0, 8'h84);
    enc.pulse(0);
    rchk(ADDR_COUNT0, 8'hff, 8'h00);
    // reset in mid-run restores the defaults
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rchk(ADDR_CTRLLO0, 8'hff, 8'h10);
    rchk(ADDR_COUNT1, 8'hff, 8'h00);
    $display("enable and reset done");
    conclude();
  end
endmodule : tb
